// file: hw/hlcs_top.sv
// Command decoder of the bit-oriented link controller, Wishbone slave.
// What this block does
// RULE1: A4 sets, 64 clears one-bit-delay bits.
// RULE2: 97 sets, 57 clears transfer mode bits.
// RULE3: 91 sets, 51 clears operating mode bits.
// RULE4: A0 sets, 60 clears serial mode bits.
// RULE5: C0 takes two lengths, reports, interrupts.
// RULE6: C1 takes lengths, two addresses, same results.
// RULE7: C2 loop receive reports and interrupts.
// RULE8: C5 disables receive, no result.
// RULE9: C8 takes length, address/control when buffered.
// RULE10: CA loop transmit, same parameters, interrupts.
// RULE11: C9 takes only length, interrupts.
// RULE12: Aborts CC, CE, CD give transmit code.
// RULE13: 22 and 23 return port A, B.
// RULE14: A3 sets port B bits by mask.
// RULE15: 63 clears port B bits four..one.
// RULE16: Address and control results only when buffered.
// RULE17: Sixteen-bit values travel low byte first.
// RULE18: Host holds reset ten clocks at least.
// RULE19: Host waits two clocks before first write.
// RULE20: Reset masks carry zeros where bits clear.
// RULE21: Non-buffered length counts two extra bytes.
// RULE22: Set masks are ORed into target.
// RULE23: Execute only after all parameters arrive.
`timescale 1ns/1ps
`include "hlcs_defs.svh"
module hlcs_top
	import hlcs_pkg::*;
(
	// System.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Modem ports and link side.
	input  wire logic [7:0]  port_a_i,
	input  wire logic [7:0]  port_b_i,
	input  wire logic        data_clk_i,
	input  wire logic        rx_done_i,
	input  wire logic [15:0] rx_count_i,
	input  wire logic [7:0]  rx_addr_i,
	input  wire logic [7:0]  rx_ctrl_i,
	input  wire logic        tx_done_i,
	output logic      [7:0]  port_b_o,
	output logic      [3:0]  user_modem_outputs_o,
	output logic             rx_irq_o,
	output logic             tx_irq_o,
	output logic             rx_en_o,
	output logic             tx_busy_o,
	output logic      [7:0]  dly_mode_o,
	output logic      [7:0]  xfr_mode_o,
	output logic      [7:0]  opm_mode_o,
	output logic      [7:0]  sio_mode_o
);
	hlcs_state_t state_q;
	logic [7:0]  op_q, need_q, pcnt_q, res_q, pb_q;
	logic [7:0]  par_q [0:3];
	logic [7:0]  dly_q, xfr_q, opm_q, sio_q;
	logic [7:0]  rxr_q [0:4];
	logic [2:0]  rxr_n_q, rxr_ptr_q;
	logic [7:0]  txr_q;
	logic        txr_v_q, rxi_q, txi_q, rxe_q, txb_q, ack_q;
	logic [31:0] dat_q;
	logic [7:0]  pa_s1, pa_s2, pb_s1, pb_s2;
	logic [3:0]  rx_s, tx_s, dc_s;
	logic [7:0]  rx_a_s1, rx_a_s2, rx_c_s1, rx_c_s2;
	logic [15:0] rx_n_s1, rx_n_s2;

	// Bus decode; a classic cycle is acked two clocks after it is seen.
	// The master holds its request while ack_o shows, so that cycle is not taken twice.
	wire req      = cyc_i & stb_i & ~ack_q & ~ack_o;
	wire wr_cmd   = req & we_i & sel_i[0] & (adr_i == `HLCS_OFF_CMD);
	wire wr_par   = req & we_i & sel_i[0] & (adr_i == `HLCS_OFF_PAR);
	wire rd_res   = req & ~we_i & (adr_i == `HLCS_OFF_RES);
	wire buffered = opm_q[`HLCS_OPM_BUF];
	wire rx_ev    = rx_s[2] & ~rx_s[3];
	wire tx_ev    = tx_s[2] & ~tx_s[3];
	wire [7:0] wbyte = dat_i[7:0];

	// Parameter count per opcode; only the transmit frame and loop counts depend on mode.
	// RULE9 address and control
	wire [7:0] tx_need = buffered ? 8'h04 : 8'h02;
	logic [7:0] need_d;
	always_comb begin
		case (wbyte)
			`HLCS_OP_SET_DLY, `HLCS_OP_CLR_DLY, `HLCS_OP_SET_XFR,
			`HLCS_OP_CLR_XFR, `HLCS_OP_SET_OPM, `HLCS_OP_CLR_OPM,
			`HLCS_OP_SET_SIO, `HLCS_OP_CLR_SIO, `HLCS_OP_SET_PB,
			`HLCS_OP_CLR_PB: need_d = 8'h01;
			`HLCS_OP_RX_GEN: need_d = 8'h02;
			`HLCS_OP_RX_SEL, `HLCS_OP_RX_LOOP: need_d = 8'h04;
			`HLCS_OP_TX_FRM, `HLCS_OP_TX_LOOP: need_d = tx_need;
			`HLCS_OP_TX_TRN: need_d = 8'h02;
			default: need_d = 8'h00;
		endcase
	end

	// Receive length result: non-buffered adds the address and control bytes.
	// RULE21 length bias
	wire [15:0] rx_len = buffered ? rx_n_s2 : rx_n_s2 + `HLCS_NB_BIAS;

	// Synchronisers for the modem ports, link events and data clock.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pa_s1 <= 8'h00; pa_s2 <= 8'h00; pb_s1 <= 8'h00; pb_s2 <= 8'h00;
			rx_s <= 4'h0; tx_s <= 4'h0; dc_s <= 4'h0;
			rx_a_s1 <= 8'h00; rx_a_s2 <= 8'h00; rx_c_s1 <= 8'h00; rx_c_s2 <= 8'h00;
			rx_n_s1 <= 16'h0000; rx_n_s2 <= 16'h0000;
		end else begin
			pa_s1 <= port_a_i; pa_s2 <= pa_s1; pb_s1 <= port_b_i; pb_s2 <= pb_s1;
			rx_s <= {rx_s[2:0], rx_done_i}; tx_s <= {tx_s[2:0], tx_done_i};
			dc_s <= {dc_s[2:0], data_clk_i};
			rx_a_s1 <= rx_addr_i; rx_a_s2 <= rx_a_s1;
			rx_c_s1 <= rx_ctrl_i; rx_c_s2 <= rx_c_s1;
			rx_n_s1 <= rx_count_i; rx_n_s2 <= rx_n_s1;
		end
	end

	// Wishbone ack and read data; unmapped reads return zero.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req & ~we_i) begin
				case (adr_i)
					`HLCS_OFF_RES:  dat_q <= {24'h00_0000,
						rxr_ptr_q < rxr_n_q ? rxr_q[rxr_ptr_q] : (txr_v_q ? txr_q : res_q)};
					`HLCS_OFF_STAT: dat_q <= {28'h000_0000, txi_q, rxi_q, 1'b0,
						state_q != HLCS_IDLE};
					default:        dat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Command sequencer: opcode, parameter bytes, then one execute cycle.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= HLCS_IDLE;
			op_q    <= 8'h00;
			need_q  <= 8'h00;
			pcnt_q  <= 8'h00;
		end else begin
			case (state_q)
				HLCS_IDLE: if (wr_cmd) begin
					op_q   <= wbyte;
					need_q <= need_d;
					pcnt_q <= 8'h00;
					state_q <= (need_d == 8'h00) ? HLCS_EXEC : HLCS_PARAM;
				end
				// RULE23 wait for parameters
				HLCS_PARAM: if (wr_par) begin
					pcnt_q <= pcnt_q + 8'h01;
					if (pcnt_q + 8'h01 == need_q)
						state_q <= HLCS_EXEC;
				end
				HLCS_EXEC: state_q <= HLCS_IDLE;
				default: state_q <= HLCS_IDLE;
			endcase
		end
	end

	// Parameter capture; lengths arrive low byte then high byte.
	// RULE17 byte order
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++) par_q[i] <= 8'h00;
		end else if (state_q == HLCS_PARAM && wr_par) begin
			par_q[pcnt_q[1:0]] <= wbyte;
		end
	end

	// Mode registers: set commands OR the mask, reset commands AND it; the port B reset ANDs it on bits four..one only.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dly_q <= `HLCS_RST_MODE; xfr_q <= `HLCS_RST_MODE;
			opm_q <= `HLCS_RST_MODE; sio_q <= `HLCS_RST_MODE;
			pb_q  <= `HLCS_RST_MODE;
		end else if (state_q == HLCS_EXEC) begin
			case (op_q)
				// RULE1 RULE22 delay mode
				`HLCS_OP_SET_DLY: dly_q <= dly_q | par_q[0];
				// RULE20 RULE1 AND clear
				`HLCS_OP_CLR_DLY: dly_q <= dly_q & par_q[0];
				// RULE2 transfer mode
				`HLCS_OP_SET_XFR: xfr_q <= xfr_q | par_q[0];
				`HLCS_OP_CLR_XFR: xfr_q <= xfr_q & par_q[0];
				// RULE3 operating mode
				`HLCS_OP_SET_OPM: opm_q <= opm_q | par_q[0];
				`HLCS_OP_CLR_OPM: opm_q <= opm_q & par_q[0];
				// RULE4 serial mode
				`HLCS_OP_SET_SIO: sio_q <= sio_q | par_q[0];
				`HLCS_OP_CLR_SIO: sio_q <= sio_q & par_q[0];
				// RULE14 set port bits
				`HLCS_OP_SET_PB:  pb_q  <= pb_q | par_q[0];
				// RULE15 clear user bits
				`HLCS_OP_CLR_PB:  pb_q  <= pb_q & (par_q[0] | ~`HLCS_PB_USER);
				default: ;
			endcase
		end
	end

	// Receive and transmit engines: enables, results and sticky flags.
	// Completion set wins over a result read in the same cycle.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rxe_q <= 1'b0; txb_q <= 1'b0; rxi_q <= 1'b0; txi_q <= 1'b0;
			rxr_n_q <= 3'd0; rxr_ptr_q <= 3'd0; txr_q <= 8'h00; txr_v_q <= 1'b0;
			res_q <= 8'h00;
			for (int i = 0; i < 5; i++) rxr_q[i] <= 8'h00;
		end else begin
			if (rd_res) begin
				if (rxr_ptr_q < rxr_n_q) rxr_ptr_q <= rxr_ptr_q + 3'd1;
				else if (txr_v_q) txr_v_q <= 1'b0;
				if (rxr_ptr_q + 3'd1 >= rxr_n_q) rxi_q <= 1'b0;
				if (!(rxr_ptr_q < rxr_n_q)) txi_q <= 1'b0;
			end
			if (state_q == HLCS_EXEC) begin
				case (op_q)
					// RULE5 RULE6 RULE7 start receive
					`HLCS_OP_RX_GEN, `HLCS_OP_RX_SEL, `HLCS_OP_RX_LOOP: rxe_q <= 1'b1;
					// RULE8 disable receive
					`HLCS_OP_RX_DIS: rxe_q <= 1'b0;
					// RULE9 RULE10 RULE11 start transmit
					`HLCS_OP_TX_FRM, `HLCS_OP_TX_LOOP, `HLCS_OP_TX_TRN: txb_q <= 1'b1;
					// RULE12 abort gives code
					`HLCS_OP_AB_FRM, `HLCS_OP_AB_LOOP, `HLCS_OP_AB_TRN: begin
						txb_q <= 1'b0; txr_q <= `HLCS_TIC_ABORT;
						txr_v_q <= 1'b1; txi_q <= 1'b1;
					end
					// RULE13 read port A
					`HLCS_OP_RD_PA: res_q <= pa_s2;
					// RULE13 read port B
					`HLCS_OP_RD_PB: res_q <= pb_s2;
					default: ;
				endcase
			end
			// RULE5 RULE16 receive results
			if (rx_ev && rxe_q) begin
				rxr_q[0] <= `HLCS_RIC_OK;
				rxr_q[1] <= rx_len[7:0];
				rxr_q[2] <= rx_len[15:8];
				rxr_q[3] <= rx_a_s2;
				rxr_q[4] <= rx_c_s2;
				rxr_n_q <= buffered ? 3'd5 : 3'd3;
				rxr_ptr_q <= 3'd0;
				rxi_q <= 1'b1;
				rxe_q <= 1'b0;
			end
			// RULE9 transmit completion
			if (tx_ev && txb_q) begin
				txb_q <= 1'b0; txr_q <= `HLCS_TIC_OK; txr_v_q <= 1'b1; txi_q <= 1'b1;
			end
		end
	end

	// Registered outputs.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000; ack_o <= 1'b0; port_b_o <= 8'h00;
			user_modem_outputs_o <= 4'h0; rx_irq_o <= 1'b0; tx_irq_o <= 1'b0;
			rx_en_o <= 1'b0; tx_busy_o <= 1'b0;
			dly_mode_o <= 8'h00; xfr_mode_o <= 8'h00;
			opm_mode_o <= 8'h00; sio_mode_o <= 8'h00;
		end else begin
			dat_o <= dat_q; ack_o <= ack_q; port_b_o <= pb_q;
			user_modem_outputs_o <= pb_q[4:1]; rx_irq_o <= rxi_q; tx_irq_o <= txi_q;
			rx_en_o <= rxe_q; tx_busy_o <= txb_q;
			dly_mode_o <= dly_q; xfr_mode_o <= xfr_q;
			opm_mode_o <= opm_q; sio_mode_o <= sio_q;
		end
	end

	// Checks next to the logic.
	AST_EXEC_AFTER_PARAMS: assert property (@(posedge clk_i) disable iff (rst_i) // RULE23
		state_q == HLCS_EXEC |-> $past(state_q) == HLCS_IDLE || pcnt_q == need_q)
		else $error("Command executed before all parameters arrived.");
	AST_SET_DLY_OR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
		state_q == HLCS_EXEC && op_q == `HLCS_OP_SET_DLY |=> dly_q == ($past(dly_q) | $past(par_q[0])))
		else $error("Delay mode set did not OR the mask.");
	AST_CLR_OPM_AND: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
		state_q == HLCS_EXEC && op_q == `HLCS_OP_CLR_OPM |=> opm_q == ($past(opm_q) & $past(par_q[0])))
		else $error("Operating mode reset did not AND the mask.");
	AST_XFR_SET: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
		state_q == HLCS_EXEC && op_q == `HLCS_OP_SET_XFR |=> (xfr_q & $past(par_q[0])) == $past(par_q[0]))
		else $error("Transfer mode bits not set.");
	AST_SIO_CLR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
		state_q == HLCS_EXEC && op_q == `HLCS_OP_CLR_SIO |=> (sio_q & ~$past(par_q[0])) == 8'h00)
		else $error("Serial mode bits not cleared.");
	AST_PB_CLR_USER: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
		state_q == HLCS_EXEC && op_q == `HLCS_OP_CLR_PB |=> ##1 port_b_o[0] == $past(pb_q[0], 2))
		else $error("Port B clear touched a non-user bit.");
	AST_RX_RESULT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
		rx_ev && rxe_q |=> rxr_n_q == (buffered ? 3'd5 : 3'd3) && rxi_q)
		else $error("Receive result count wrong for mode.");
	AST_ABORT_TIC: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
		state_q == HLCS_EXEC && op_q == `HLCS_OP_AB_FRM |=>
		txi_q && txr_q == `HLCS_TIC_ABORT ##1 tx_irq_o)
		else $error("Abort gave no transmit result.");
	AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("Ack held longer than one cycle.");
	// Mask arithmetic of delay reset, serial set and port B set, receive disable, and the result words.
	AST_CLR_DLY_AND: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
		state_q == HLCS_EXEC && op_q == `HLCS_OP_CLR_DLY |=> dly_q == ($past(dly_q) & $past(par_q[0])))
		else $error("Delay mode reset did not AND the mask.");
	AST_SIO_SET_OR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
		state_q == HLCS_EXEC && op_q == `HLCS_OP_SET_SIO |=> sio_q == ($past(sio_q) | $past(par_q[0])))
		else $error("Serial mode set did not OR the mask.");
	AST_PB_SET_OR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
		state_q == HLCS_EXEC && op_q == `HLCS_OP_SET_PB |=> pb_q == ($past(pb_q) | $past(par_q[0])))
		else $error("Port B set did not OR the mask.");
	AST_PORT_A_RES: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
		state_q == HLCS_EXEC && op_q == `HLCS_OP_RD_PA |=> res_q == $past(pa_s2))
		else $error("Port A value not placed in the result.");
	AST_RX_DIS_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
		state_q == HLCS_EXEC && op_q == `HLCS_OP_RX_DIS |=> !rxe_q)
		else $error("Receive disable left the receiver on.");
	AST_NB_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // RULE21
		rx_ev && rxe_q && !buffered |=> {rxr_q[2], rxr_q[1]} == $past(rx_n_s2) + `HLCS_NB_BIAS)
		else $error("Non-buffered length lacks the two extra bytes.");
	AST_BUF_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // RULE21
		rx_ev && rxe_q && buffered |=> {rxr_q[2], rxr_q[1]} == $past(rx_n_s2))
		else $error("Buffered length differs from the data count.");
	AST_TX_DONE_TIC: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
		tx_ev && txb_q |=> txi_q && txr_q == `HLCS_TIC_OK && !txb_q)
		else $error("Transmit completion gave no result code.");
	COV_RX: cover property (@(posedge clk_i) disable iff (rst_i) rx_ev && rxe_q);
	COV_TX: cover property (@(posedge clk_i) disable iff (rst_i) tx_ev && txb_q);
	COV_PB: cover property (@(posedge clk_i) disable iff (rst_i)
		state_q == HLCS_EXEC && op_q == `HLCS_OP_SET_PB);
	COV_ABORT: cover property (@(posedge clk_i) disable iff (rst_i)
		state_q == HLCS_EXEC && op_q == `HLCS_OP_AB_LOOP);
	COV_RX_BUF: cover property (@(posedge clk_i) disable iff (rst_i) rx_ev && rxe_q && buffered);
endmodule // hlcs_top

// file: hw/hlcs_defs.svh
// Offsets, field positions, reset values and opcodes of the link command set.
`ifndef HLCS_DEFS_SVH
`define HLCS_DEFS_SVH
// Wishbone register offsets (byte addresses).
`define HLCS_OFF_CMD      4'h0
`define HLCS_OFF_PAR      4'h4
`define HLCS_OFF_RES      4'h8
`define HLCS_OFF_STAT     4'hC
// Status word field positions.
`define HLCS_ST_BUSY      0
`define HLCS_ST_RESV      1
`define HLCS_ST_RXI       2
`define HLCS_ST_TXI       3
// Opcodes.
`define HLCS_OP_SET_DLY   8'hA4
`define HLCS_OP_CLR_DLY   8'h64
`define HLCS_OP_SET_XFR   8'h97
`define HLCS_OP_CLR_XFR   8'h57
`define HLCS_OP_SET_OPM   8'h91
`define HLCS_OP_CLR_OPM   8'h51
`define HLCS_OP_SET_SIO   8'hA0
`define HLCS_OP_CLR_SIO   8'h60
`define HLCS_OP_RX_GEN    8'hC0
`define HLCS_OP_RX_SEL    8'hC1
`define HLCS_OP_RX_LOOP   8'hC2
`define HLCS_OP_RX_DIS    8'hC5
`define HLCS_OP_TX_FRM    8'hC8
`define HLCS_OP_TX_TRN    8'hC9
`define HLCS_OP_TX_LOOP   8'hCA
`define HLCS_OP_AB_FRM    8'hCC
`define HLCS_OP_AB_TRN    8'hCD
`define HLCS_OP_AB_LOOP   8'hCE
`define HLCS_OP_RD_PA     8'h22
`define HLCS_OP_RD_PB     8'h23
`define HLCS_OP_SET_PB    8'hA3
`define HLCS_OP_CLR_PB    8'h63
// Operating mode bit that selects buffered mode.
`define HLCS_OPM_BUF      0
// Port B user bits four down to one.
`define HLCS_PB_USER      8'h1E
// Result codes and the fixed length bias of non-buffered mode.
`define HLCS_RIC_OK       8'h00
`define HLCS_TIC_OK       8'h0C
`define HLCS_TIC_ABORT    8'h0D
`define HLCS_NB_BIAS      16'h0002
`define HLCS_RST_MODE     8'h00
`endif

// file: hw/hlcs_pkg.sv
// Types shared by the link command set decoder.
package hlcs_pkg;
	typedef enum logic [1:0] {HLCS_IDLE, HLCS_PARAM, HLCS_EXEC} hlcs_state_t;
endpackage

// file: tb/hlcs_modem_model.sv
// Link-side stand-in for the decoder: modem ports, receiver and transmitter.
`timescale 1ns/1ps
module hlcs_modem_model (
	// System.
	input  wire logic        clk_i,
	input  wire logic        tx_busy_i,
	// Link side.
	output logic      [7:0]  port_a_o,
	output logic      [7:0]  port_b_o,
	output logic             data_clk_o,
	output logic             rx_done_o,
	output logic      [15:0] rx_count_o,
	output logic      [7:0]  rx_addr_o,
	output logic      [7:0]  rx_ctrl_o,
	output logic             tx_done_o
);
	logic        in_frame = 1'b0;
	int unsigned tx_cnt   = 0;
	// Quiet lines at start; the data clock is off-phase to the system clock.
	initial begin
		{port_a_o, port_b_o, data_clk_o, rx_done_o} = '0;
		{rx_count_o, rx_addr_o, rx_ctrl_o} = '0;
		#3;
		forever #80 data_clk_o = in_frame ? ~data_clk_o : 1'b0;
	end
	// A slow transmitter; an aborted send drops busy and never completes.
	always @(posedge clk_i) begin
		tx_cnt <= tx_busy_i ? tx_cnt + 1 : 0;
		tx_done_o <= tx_busy_i && tx_cnt >= 40;
	end
	// Fields stand steady well before the done edge, then are scrambled.
	task automatic frame(input logic [15:0] n, input logic [7:0] a, input logic [7:0] c);
		in_frame = 1'b1;
		@(posedge clk_i);
		rx_count_o <= n;
		rx_addr_o <= a;
		rx_ctrl_o <= c;
		repeat (6) @(posedge clk_i);
		rx_done_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		rx_done_o <= 1'b0;
		rx_count_o <= ~n;
		rx_addr_o <= ~a;
		rx_ctrl_o <= ~c;
		in_frame = 1'b0;
	endtask
	task automatic set_ports(input logic [7:0] a, input logic [7:0] b);
		@(posedge clk_i);
		port_a_o <= a;
		port_b_o <= b;
	endtask
endmodule // hlcs_modem_model

// file: tb/hlcs_top_bench.sv
// Self-checking bench for the link command decoder.
`timescale 1ns/1ps
`include "hlcs_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module hlcs_top_bench;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [3:0]  adr_i;
	logic [31:0] dat_i, dat_o, exp_v;
	logic [7:0]  pa, pb, rxa, rxk, pbo, dly, xfr, opm, sio;
	logic [15:0] rxc;
	logic [3:0]  usr;
	logic        dclk, rxd, txd, rx_irq_o, tx_irq_o, rx_en_o, tx_busy_o;
	logic [31:0] exp_q [$];
	logic [7:0]  prm [4];
	logic [7:0]  modes [4] = '{default: 8'h00};
	logic [7:0]  set_op [4] = '{`HLCS_OP_SET_DLY, `HLCS_OP_SET_XFR,
		`HLCS_OP_SET_OPM, `HLCS_OP_SET_SIO};
	logic [7:0]  clr_op [4] = '{`HLCS_OP_CLR_DLY, `HLCS_OP_CLR_XFR,
		`HLCS_OP_CLR_OPM, `HLCS_OP_CLR_SIO};
	logic [7:0]  tx_op [3] = '{`HLCS_OP_TX_FRM, `HLCS_OP_TX_LOOP, `HLCS_OP_TX_TRN};
	logic [7:0]  ab_op [3] = '{`HLCS_OP_AB_FRM, `HLCS_OP_AB_LOOP, `HLCS_OP_AB_TRN};
	int          tx_n [3] = '{4, 4, 2};
	int          err_count = 0;
	int          checked = 0;
	logic [7:0]  m, a, b;
	logic [15:0] n;
	hlcs_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.port_a_i(pa), .port_b_i(pb), .data_clk_i(dclk), .rx_done_i(rxd), .rx_count_i(rxc),
		.rx_addr_i(rxa), .rx_ctrl_i(rxk), .tx_done_i(txd), .port_b_o(pbo),
		.user_modem_outputs_o(usr), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o),
		.rx_en_o(rx_en_o), .tx_busy_o(tx_busy_o), .dly_mode_o(dly), .xfr_mode_o(xfr),
		.opm_mode_o(opm), .sio_mode_o(sio));
	hlcs_modem_model mdm (.clk_i(clk_i), .tx_busy_i(tx_busy_o), .port_a_o(pa),
		.port_b_o(pb), .data_clk_o(dclk), .rx_done_o(rxd), .rx_count_o(rxc),
		.rx_addr_o(rxa), .rx_ctrl_o(rxk), .tx_done_o(txd));
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Classic cycle: hold everything until ack is sampled, then release.
	task automatic wb(input logic w, input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i} <= {2'b11, w, ad};
		dat_i <= {24'h00_0000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		{cyc_i, stb_i} <= 2'b00;
	endtask
	task automatic rd(input logic [3:0] ad, input logic [7:0] e);
		exp_q.push_back({24'h00_0000, e});
		wb(1'b0, ad, 8'h00);
	endtask
	task automatic cmd(input logic [7:0] op, input int cnt, input logic chk);
		wb(1'b1, `HLCS_OFF_CMD, op);
		for (int i = 0; i < cnt; i++) begin
			if (chk && i == cnt - 1) `CHK({rx_en_o, tx_busy_o}, 2'b00)
			wb(1'b1, `HLCS_OFF_PAR, prm[i]);
		end
		repeat (3) @(posedge clk_i);
	endtask
	task automatic setbuf(input logic bf);
		prm[0] = 8'h00;
		cmd(`HLCS_OP_CLR_OPM, 1, 1'b0);
		prm[0] = {7'h00, bf};
		cmd(`HLCS_OP_SET_OPM, 1, 1'b0);
	endtask
	task automatic rx_res(input logic bf, input logic [7:0] op, input int cnt);
		cmd(`HLCS_OP_RX_DIS, 0, 1'b0);
		`CHK(rx_en_o, 1'b0)
		for (int i = 0; i < 4; i++) prm[i] = 8'($urandom);
		cmd(op, cnt, 1'b1);
		`CHK(rx_en_o, 1'b1)
		n = 16'($urandom_range(1, 900));
		mdm.frame(n, prm[2], prm[3]);
		for (int i = 0; i < 60 && rx_irq_o !== 1'b1; i++) @(posedge clk_i);
		if (!bf) n = n + 16'h0002;
		rd(`HLCS_OFF_STAT, 8'h04);
		rd(`HLCS_OFF_RES, `HLCS_RIC_OK);
		rd(`HLCS_OFF_RES, n[7:0]);
		rd(`HLCS_OFF_RES, n[15:8]);
		if (bf) rd(`HLCS_OFF_RES, prm[2]);
		if (bf) rd(`HLCS_OFF_RES, prm[3]);
		repeat (3) @(posedge clk_i);
		`CHK(rx_irq_o, 1'b0)
	endtask
	task automatic tx_res(input logic [7:0] code);
		for (int i = 0; i < 90 && tx_irq_o !== 1'b1; i++) @(posedge clk_i);
		rd(`HLCS_OFF_STAT, 8'h08);
		rd(`HLCS_OFF_RES, code);
	endtask
	// Every read answer is matched with the oldest pending note.
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && cyc_i && !we_i) begin
			exp_v = exp_q.pop_front();
			`CHK(dat_o, exp_v)
		end
	end
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Watchdog sized well above the whole sequence.
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		complete_run();
	end
	initial begin
		{rst_i, cyc_i, stb_i, we_i, adr_i, dat_i} = {1'b1, 39'h0};
		void'($urandom(83));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		// Two sets then a clear per group, so OR and AND both show.
		for (int g = 0; g < 4; g++) begin
			for (int k = 0; k < 3; k++) begin
				prm[0] = 8'($urandom);
				modes[g] = (k < 2) ? (modes[g] | prm[0]) : (modes[g] & prm[0]);
				cmd((k < 2) ? set_op[g] : clr_op[g], 1, 1'b0);
				`CHK({dly, xfr, opm, sio}, {modes[0], modes[1], modes[2], modes[3]})
			end
		end
		$display("mode test done");
		prm[0] = 8'($urandom);
		m = prm[0];
		cmd(`HLCS_OP_SET_PB, 1, 1'b0);
		`CHK({pbo, usr}, {m, m[4:1]})
		prm[0] = 8'($urandom) | 8'hE1;
		m = m & prm[0];
		cmd(`HLCS_OP_CLR_PB, 1, 1'b0);
		`CHK({pbo, usr}, {m, m[4:1]})
		a = 8'($urandom);
		b = 8'($urandom);
		mdm.set_ports(a, b);
		cmd(`HLCS_OP_RD_PA, 0, 1'b0);
		rd(`HLCS_OFF_RES, a);
		cmd(`HLCS_OP_RD_PB, 0, 1'b0);
		rd(`HLCS_OFF_RES, b);
		rd(4'h2, 8'h00);
		$display("port test done");
		setbuf(1'b0);
		rx_res(1'b0, `HLCS_OP_RX_GEN, 2);
		setbuf(1'b1);
		rx_res(1'b1, `HLCS_OP_RX_SEL, 4);
		rx_res(1'b1, `HLCS_OP_RX_LOOP, 4);
		$display("receive test done");
		setbuf(1'b0);
		cmd(`HLCS_OP_TX_FRM, 2, 1'b1);
		tx_res(`HLCS_TIC_OK);
		setbuf(1'b1);
		for (int t = 0; t < 6; t++) begin
			cmd(tx_op[t % 3], tx_n[t % 3], 1'b1);
			`CHK(tx_busy_o, 1'b1)
			if (t >= 3) cmd(ab_op[t % 3], 0, 1'b0);
			tx_res((t >= 3) ? `HLCS_TIC_ABORT : `HLCS_TIC_OK);
		end
		$display("transmit test done");
		complete_run();
	end
endmodule // hlcs_top_bench
